// ==== event_pkt_pkg.sv ====
// constants and types for the discrete event packetizer
package event_pkt_pkg;
    // ************************************************
    // body word layout
    // ************************************************
    localparam int unsigned MODE_TRIG_BIT  = 0;
    localparam int unsigned MODE_ALIGN_BIT = 1;
    localparam int unsigned LEN_LSB        = 3;
    localparam int unsigned LEN_W          = 5;
    localparam int unsigned STATE_W        = 32;
    localparam int unsigned RTC_W          = 48;
    localparam int unsigned WORD_W         = 16;
    localparam int unsigned BLEN_W         = 20;
    localparam logic [5:0]  FULL_WIDTH     = 6'h20;
    localparam logic [BLEN_W-1:0] BYTES_PER_WORD = 20'h00002;
    localparam logic [15:0] TICK_RESET     = 16'h0000;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_CSW_LO = 4'b0001,
        S_CSW_HI = 4'b0010,
        S_WAIT   = 4'b0011,
        S_TS0    = 4'b0100,
        S_TS1    = 4'b0101,
        S_TS2    = 4'b0110,
        S_TS3    = 4'b0111,
        S_ST0    = 4'b1000,
        S_ST1    = 4'b1001
    } pkt_state_t;
endpackage

// ==== discrete_event_packetizer.sv ====
// discrete event packet body builder, 16-bit word stream out
// What this block does
// - records one to 32 discrete inputs per event, count set by configuration.
// - body opens with 32-bit word; mode in bits 2-0, bits 31-8 reserved.
// - bits 7-3 hold bits per event; zero means 32.
// - mode bit 0 clear records on change, set records on interval.
// - mode bit 1 reports alignment, 0 lsb, 1 msb; mode bit 2 reserved.
// - state word bit n is level of discrete input n when lsb aligned; msb alignment moves short events up.
// - each state word is directly preceded by a time stamp header only.
// - time stamp is 64 bits, low long word first then high.
// - default stamp is 48-bit relative time at event, upper 16 bits zero.
// - absolute time flag set puts absolute time, in flagged format, in stamp.
// - 16-bit words low half first: config word, four stamp, two state words.
module discrete_event_packetizer (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] discrete_in,
    input  wire logic [4:0]  event_len,
    input  wire logic        interval_mode,
    input  wire logic        align_msb,
    input  wire logic [15:0] interval_ticks,
    input  wire logic        abs_time_en,
    input  wire logic [63:0] abs_time,
    input  wire logic [47:0] rel_time,
    input  wire logic        pkt_start,
    input  wire logic        pkt_end,
    input  wire logic        body_ready,
    output logic      [15:0] body_data,
    output logic             body_valid,
    output logic             body_done,
    output logic      [19:0] body_len_bytes,
    output logic             busy
);
    // ************************************************
    // state
    // ************************************************
    event_pkt_pkg::pkt_state_t state_reg, state_next;
    logic [4:0]  len_reg, len_next;
    logic        intv_reg, intv_next;
    logic        msb_reg, msb_next;
    logic        abs_reg, abs_next;
    logic [31:0] last_reg, last_next;
    logic [31:0] evt_reg, evt_next;
    logic [63:0] ts_reg, ts_next;
    logic [15:0] tick_reg, tick_next;
    logic        tpend_reg, tpend_next;
    logic        epend_reg, epend_next;
    logic [15:0] data_reg, data_next;
    logic        valid_reg, valid_next;
    logic        done_reg, done_next;
    logic [19:0] blen_reg, blen_next;
    logic        busy_reg, busy_next;

    logic [5:0]  width;
    logic [31:0] mask;
    logic [31:0] aligned;
    logic [31:0] csw;
    logic        can_load;
    logic        tick_hit;
    logic        evt_now;

    // ************************************************
    // next-state logic
    // ************************************************
    always_comb begin
        width    = (len_reg == 5'h00) ? event_pkt_pkg::FULL_WIDTH : {1'b0, len_reg};
        mask     = 32'hffff_ffff >> (event_pkt_pkg::FULL_WIDTH - width);
        // inputs kept in place, unused bits cleared, then moved up for msb
        aligned  = msb_reg ? ((discrete_in & mask) << (event_pkt_pkg::FULL_WIDTH - width))
                           : (discrete_in & mask);
        csw      = 32'h0000_0000;
        csw[event_pkt_pkg::LEN_LSB +: event_pkt_pkg::LEN_W] = len_reg;
        csw[event_pkt_pkg::MODE_TRIG_BIT]  = intv_reg;
        csw[event_pkt_pkg::MODE_ALIGN_BIT] = msb_reg;
        can_load = !valid_reg || body_ready;
        tick_hit = intv_reg && (tick_reg + 16'h0001 >= interval_ticks);
        evt_now  = intv_reg ? tpend_reg : (aligned != last_reg);

        state_next = state_reg;
        len_next   = len_reg;
        intv_next  = intv_reg;
        msb_next   = msb_reg;
        abs_next   = abs_reg;
        last_next  = last_reg;
        evt_next   = evt_reg;
        ts_next    = ts_reg;
        tick_next  = tick_hit ? event_pkt_pkg::TICK_RESET : tick_reg + 16'h0001;
        tpend_next = tpend_reg;
        epend_next = epend_reg || pkt_end;
        data_next  = data_reg;
        valid_next = valid_reg && !body_ready;
        done_next  = 1'b0;
        blen_next  = blen_reg;

        case (state_reg)
            event_pkt_pkg::S_IDLE: begin
                epend_next = 1'b0;
                tpend_next = 1'b0;
                tick_next  = event_pkt_pkg::TICK_RESET;
                if (pkt_start) begin
                    len_next   = event_len;
                    intv_next  = interval_mode;
                    msb_next   = align_msb;
                    abs_next   = abs_time_en;
                    blen_next  = 20'h00000;
                    state_next = event_pkt_pkg::S_CSW_LO;
                end
            end
            event_pkt_pkg::S_CSW_LO: begin
                // first compare reference taken once the config is in force
                last_next = aligned;
                if (can_load) begin
                    data_next  = csw[15:0];
                    valid_next = 1'b1;
                    blen_next  = blen_reg + event_pkt_pkg::BYTES_PER_WORD;
                    state_next = event_pkt_pkg::S_CSW_HI;
                end
            end
            event_pkt_pkg::S_CSW_HI: begin
                if (can_load) begin
                    data_next  = csw[31:16];
                    valid_next = 1'b1;
                    blen_next  = blen_reg + event_pkt_pkg::BYTES_PER_WORD;
                    state_next = event_pkt_pkg::S_WAIT;
                end
            end
            event_pkt_pkg::S_WAIT: begin
                // events win over a pending close
                if (evt_now) begin
                    evt_next   = aligned;
                    last_next  = aligned;
                    ts_next    = abs_reg ? abs_time : {16'h0000, rel_time};
                    tpend_next = tick_hit;
                    state_next = event_pkt_pkg::S_TS0;
                end else if (epend_reg && !valid_reg) begin
                    done_next  = 1'b1;
                    state_next = event_pkt_pkg::S_IDLE;
                end
            end
            event_pkt_pkg::S_TS0,
            event_pkt_pkg::S_TS1,
            event_pkt_pkg::S_TS2,
            event_pkt_pkg::S_TS3: begin
                if (can_load) begin
                    data_next  = ts_reg[16*state_reg[1:0] +: 16];
                    valid_next = 1'b1;
                    blen_next  = blen_reg + event_pkt_pkg::BYTES_PER_WORD;
                    state_next = (state_reg == event_pkt_pkg::S_TS3) ? event_pkt_pkg::S_ST0
                               : event_pkt_pkg::pkt_state_t'(state_reg + 4'h1);
                end
            end
            event_pkt_pkg::S_ST0: begin
                if (can_load) begin
                    data_next  = evt_reg[15:0];
                    valid_next = 1'b1;
                    blen_next  = blen_reg + event_pkt_pkg::BYTES_PER_WORD;
                    state_next = event_pkt_pkg::S_ST1;
                end
            end
            event_pkt_pkg::S_ST1: begin
                if (can_load) begin
                    data_next  = evt_reg[31:16];
                    valid_next = 1'b1;
                    blen_next  = blen_reg + event_pkt_pkg::BYTES_PER_WORD;
                    state_next = event_pkt_pkg::S_WAIT;
                end
            end
            default: state_next = event_pkt_pkg::S_IDLE;
        endcase
        // a tick landing while the packet is busy stays pending
        if (tick_hit && state_reg != event_pkt_pkg::S_IDLE) begin
            tpend_next = 1'b1;
        end
        // registered so the busy pin comes straight from a flop
        busy_next = (state_next != event_pkt_pkg::S_IDLE);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= event_pkt_pkg::S_IDLE;
            len_reg   <= 5'h00;
            intv_reg  <= 1'b0;
            msb_reg   <= 1'b0;
            abs_reg   <= 1'b0;
            last_reg  <= 32'h0000_0000;
            evt_reg   <= 32'h0000_0000;
            ts_reg    <= 64'h0000_0000_0000_0000;
            tick_reg  <= 16'h0000;
            tpend_reg <= 1'b0;
            epend_reg <= 1'b0;
            data_reg  <= 16'h0000;
            valid_reg <= 1'b0;
            done_reg  <= 1'b0;
            blen_reg  <= 20'h00000;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            len_reg   <= len_next;
            intv_reg  <= intv_next;
            msb_reg   <= msb_next;
            abs_reg   <= abs_next;
            last_reg  <= last_next;
            evt_reg   <= evt_next;
            ts_reg    <= ts_next;
            tick_reg  <= tick_next;
            tpend_reg <= tpend_next;
            epend_reg <= epend_next;
            data_reg  <= data_next;
            valid_reg <= valid_next;
            done_reg  <= done_next;
            blen_reg  <= blen_next;
            busy_reg  <= busy_next;
        end
    end

    assign body_data      = data_reg;
    assign body_valid     = valid_reg;
    assign body_done      = done_reg;
    assign body_len_bytes = blen_reg;
    assign busy           = busy_reg;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_csw_low;
        state_reg == event_pkt_pkg::S_CSW_HI && $past(state_reg) == event_pkt_pkg::S_CSW_LO
            |-> data_reg[15:8] == 8'h00 && data_reg[7:3] == len_reg && !data_reg[2]
                && data_reg[0] == intv_reg && data_reg[1] == msb_reg;
    endproperty
    a_csw_low: assert property (p_csw_low) else $error("config word low half wrong");
    property p_csw_high;
        state_reg == event_pkt_pkg::S_WAIT && $past(state_reg) == event_pkt_pkg::S_CSW_HI
            |-> data_reg == 16'h0000 && valid_reg;
    endproperty
    a_csw_high: assert property (p_csw_high) else $error("config word high half not zero");
    property p_stamp_order;
        state_reg == event_pkt_pkg::S_TS0 && (!valid_reg || body_ready)
            |=> state_reg == event_pkt_pkg::S_TS1 && valid_reg && data_reg == ts_reg[15:0];
    endproperty
    a_stamp_order: assert property (p_stamp_order) else $error("stamp words out of order");
    property p_rel_top;
        $past(state_reg) == event_pkt_pkg::S_TS3 && state_reg == event_pkt_pkg::S_ST0 && !abs_reg
            |-> data_reg == 16'h0000;
    endproperty
    a_rel_top: assert property (p_rel_top) else $error("relative stamp top not zero");
    property p_abs_stamp;
        $past(state_reg) == event_pkt_pkg::S_TS0 && state_reg == event_pkt_pkg::S_TS1 && abs_reg
            |-> data_reg == ts_reg[15:0];
    endproperty
    a_abs_stamp: assert property (p_abs_stamp) else $error("stamp low word mismatch");
    property p_states_after_stamp;
        state_reg == event_pkt_pkg::S_ST0 |-> $past(state_reg) inside
            {event_pkt_pkg::S_TS3, event_pkt_pkg::S_ST0};
    endproperty
    a_states_after_stamp: assert property (p_states_after_stamp) else $error("state w/o stamp");
    property p_unused_zero;
        // only while the word of this packet is out: a new length may not fit an old word
        !msb_reg && state_reg inside {event_pkt_pkg::S_ST0, event_pkt_pkg::S_ST1}
            |-> (evt_reg & ~mask) == 32'h0000_0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused state bits set");
    property p_change_trig;
        state_reg == event_pkt_pkg::S_WAIT && !intv_reg && aligned != last_reg
            |=> state_reg == event_pkt_pkg::S_TS0 ##1 evt_reg == last_reg;
    endproperty
    a_change_trig: assert property (p_change_trig) else $error("change not recorded");
    property p_done_len;
        done_reg |-> !valid_reg && blen_reg[1:0] == 2'b00 && state_reg == event_pkt_pkg::S_IDLE;
    endproperty
    a_done_len: assert property (p_done_len) else $error("body close malformed");

    c_change_evt: cover property (state_reg == event_pkt_pkg::S_ST1 && !intv_reg && body_ready);
    c_intv_evt:   cover property (state_reg == event_pkt_pkg::S_ST1 && intv_reg && abs_reg);
    c_done:       cover property (done_reg && blen_reg > 20'h00004);
endmodule // discrete_event_packetizer

// ==== body_sink.sv ====
// consumer model of the packet body word stream, stalls on command
module body_sink (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] body_data,
    input  wire logic        body_valid,
    input  wire logic        stall,
    output logic             body_ready,
    output logic      [15:0] words [128],
    output int               n_words,
    output int               hold_errs
);
    logic        held;
    logic [15:0] held_data;
    // stall moves at the falling edge only, so ready never races the sampling edge
    assign body_ready = rst_b & ~stall;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            held      <= 1'b0;
            held_data <= 16'h0000;
            n_words   <= 0;
            hold_errs <= 0;
        end else begin
            if (held && (body_valid !== 1'b1 || body_data !== held_data)) begin
                hold_errs <= hold_errs + 1;
            end
            if (body_valid && body_ready) begin
                words[n_words[6:0]] <= body_data;
                n_words             <= n_words + 1;
            end
            held      <= body_valid & ~body_ready;
            held_data <= body_data;
        end
    end
endmodule // body_sink

// ==== discrete_event_packetizer_test.sv ====
// self-checking bench for the discrete event packetizer
module discrete_event_packetizer_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0]  len;
        logic        intv;
        logic        msb;
        logic        abs;
        logic [31:0] din;
    } row_t;
    // short events only lsb aligned: msb packing of them is left open
    localparam row_t ROWS [4] = '{
        '{5'h00, 1'b0, 1'b0, 1'b0, 32'h8000_0001},
        '{5'h05, 1'b0, 1'b0, 1'b0, 32'hffff_ffff},
        '{5'h00, 1'b1, 1'b1, 1'b1, 32'h5a5a_c3c3},
        '{5'h1f, 1'b1, 1'b0, 1'b0, 32'hf0f0_0f0f}};
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [31:0] discrete_in = 32'h0000_0000;
    logic [4:0]  event_len = 5'h00;
    logic        interval_mode = 1'b0;
    logic        align_msb = 1'b0;
    logic        abs_time_en = 1'b0;
    logic [63:0] abs_time = 64'h0;
    logic [47:0] rel_time = 48'h0;
    logic        pkt_start = 1'b0;
    logic        pkt_end = 1'b0;
    logic        stall = 1'b0;
    logic        stall_en = 1'b0;
    logic [15:0] interval_ticks = 16'h0040;
    logic        body_ready, body_valid, body_done, busy;
    logic [15:0] body_data;
    logic [19:0] body_len_bytes;
    logic [15:0] words [128];
    int          n_words, hold_errs, fails, n_compared, b, i, k;
    logic [63:0] ts;
    logic [31:0] st;

    always #25 core_clk = ~core_clk;
    always @(negedge core_clk) stall <= stall_en & ~stall;

    discrete_event_packetizer uut (.core_clk(core_clk), .rst_b(rst_b),
        .discrete_in(discrete_in), .event_len(event_len), .interval_mode(interval_mode),
        .align_msb(align_msb), .interval_ticks(interval_ticks), .abs_time_en(abs_time_en),
        .abs_time(abs_time), .rel_time(rel_time), .pkt_start(pkt_start), .pkt_end(pkt_end),
        .body_ready(body_ready), .body_data(body_data), .body_valid(body_valid),
        .body_done(body_done), .body_len_bytes(body_len_bytes), .busy(busy));
    body_sink sink (.core_clk(core_clk), .rst_b(rst_b), .body_data(body_data),
        .body_valid(body_valid), .stall(stall), .body_ready(body_ready), .words(words),
        .n_words(n_words), .hold_errs(hold_errs));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wait_words(input int n);
        for (k = 0; k < 2000 && n_words < n; k++) @(negedge core_clk);
        if (n_words < n) begin
            check("word count", 64'(n_words), 64'(n));
            test_done();
        end
    endtask

    task automatic pulse_start();
        pkt_start = 1'b1;
        @(negedge core_clk);
        pkt_start = 1'b0;
    endtask

    initial begin
        repeat (4) @(negedge core_clk);
        check("idle outputs", {body_data, body_valid, body_done, body_len_bytes, busy}, 64'h0);
        rst_b = 1'b1;
        foreach (ROWS[r]) begin
            stall_en = r[0];
            event_len = ROWS[r].len;
            interval_mode = ROWS[r].intv;
            align_msb = ROWS[r].msb;
            abs_time_en = ROWS[r].abs;
            rel_time = {ROWS[r].din[15:0], ROWS[r].din};
            abs_time = {ROWS[r].din, ~ROWS[r].din};
            discrete_in = 32'h0000_0000;
            b = n_words;
            pulse_start();
            wait_words(b + 2);
            pulse_start(); // second start while busy must be ignored
            discrete_in = ROWS[r].din;
            wait_words(b + 8);
            ts = ROWS[r].abs ? {ROWS[r].din, ~ROWS[r].din} : {16'h0000, rel_time};
            st = (ROWS[r].len == 5'h00) ? ROWS[r].din
                : ROWS[r].din & ((32'h1 << ROWS[r].len) - 32'h1);
            check("cfg word", 64'({words[b+1], words[b]}),
                64'({24'h0, ROWS[r].len, 1'b0, ROWS[r].msb, ROWS[r].intv}));
            for (i = 0; i < 4; i++) begin
                check("stamp word", 64'(words[b+2+i]), 64'(ts[16*i +: 16]));
            end
            check("state word", 64'({words[b+7], words[b+6]}), 64'(st));
            pkt_end = 1'b1;
            @(negedge core_clk);
            pkt_end = 1'b0;
            for (k = 0; k < 50 && body_done !== 1'b1; k++) @(negedge core_clk);
            check("done", 64'(body_done), 64'h1);
            check("busy", 64'(busy), 64'h0);
            check("body bytes", 64'(body_len_bytes), 64'h10);
            check("words sent", 64'(n_words - b), 64'h8);
        end
        stall_en = 1'b0;
        pulse_start();
        wait_words(n_words + 1);
        // sink clears its error count in reset, so read it first
        check("held words", 64'(hold_errs), 64'h0);
        rst_b = 1'b0;
        @(negedge core_clk);
        check("reset outputs", {body_data, body_valid, body_done, body_len_bytes, busy}, 64'h0);
        test_done();
    end
endmodule // discrete_event_packetizer_test
